/* File: rtl/fadc_core.sv */
// Purpose: Phase generation, thermometer latch, two-stage encoder, output stage
// Assumes: Converter clock and enables arrive from pins, sampled by the system clock
// Notes: Registers over AHB-Lite, zero wait states, always OKAY
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.

// Behaviour
// - Split converter clock into sample and auto-balance phases driving all timing.
// - Phase is clock XOR phase-select; equal levels mean sample phase.
// - Sixty-four decisions: sixty-three form the thermometer, one flags over-range.
// - Comparators high below input, low above, giving a thermometer code.
// - Latch and first encoding at auto-balance; finish encoding in next sample.
// - Six code bits and over-range flag captured together into output flops.
// - Over-range flag follows the dedicated overflow comparator decision.
// - Output word appears one and a half cycles after its sample.
// - Outputs change only when a sample phase begins.
// - Master enable low three-states code and over-range outputs.
// - With master enable high, data enable low drives code; over-range stays driven.
// - One conversion per converter clock cycle.
// - Output is straight binary, one step per sixty-fourth of reference span.
// - Over range gives all code bits high with the flag set.
module fadc_core
   import fadc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic conv_clk,
   input wire logic phase_select,
   input wire logic [CMP_N-1:0] cmp_decision,
   input wire logic master_output_enable,
   input wire logic data_bus_enable_n,
   output logic [CODE_W-1:0] sample_code,
   output logic sample_code_oe_n,
   output logic over_range_flag,
   output logic over_range_flag_oe_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);

   // ****************************************
   // Encoder functions
   // ****************************************
   function automatic logic [THERM_N-1:0] therm_edge(input logic [THERM_N-1:0] t);
      logic [THERM_N-1:0] e;
      e = '0;
      for (int i = 0; i < THERM_N - 1; i++) begin
         e[i] = t[i] & ~t[i+1];
      end
      e[THERM_N-1] = t[THERM_N-1];
      return e;
   endfunction : therm_edge

   function automatic logic [CODE_W-1:0] edge_code(input logic [THERM_N-1:0] e);
      logic [CODE_W-1:0] c;
      c = '0;
      for (int i = 0; i < THERM_N; i++) begin
         if (e[i]) begin
            c = c | CODE_W'(i + 1);
         end
      end
      return c;
   endfunction : edge_code

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic cclk_s1_reg, cclk_s2_reg, phs_s1_reg, phs_s2_reg;
   logic moe_s1_reg, moe_s2_reg, den_n_s1_reg, den_n_s2_reg;
   logic [CMP_N-1:0] cmp_s1_reg, cmp_s2_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cclk_s1_reg <= 1'b0;
         cclk_s2_reg <= 1'b0;
         phs_s1_reg <= 1'b0;
         phs_s2_reg <= 1'b0;
         moe_s1_reg <= 1'b0;
         moe_s2_reg <= 1'b0;
         den_n_s1_reg <= 1'b1;
         den_n_s2_reg <= 1'b1;
         cmp_s1_reg <= '0;
         cmp_s2_reg <= '0;
      end else begin
         cclk_s1_reg <= conv_clk;
         cclk_s2_reg <= cclk_s1_reg;
         phs_s1_reg <= phase_select;
         phs_s2_reg <= phs_s1_reg;
         moe_s1_reg <= master_output_enable;
         moe_s2_reg <= moe_s1_reg;
         den_n_s1_reg <= data_bus_enable_n;
         den_n_s2_reg <= den_n_s1_reg;
         cmp_s1_reg <= cmp_decision;
         cmp_s2_reg <= cmp_s1_reg;
      end
   end

   // ****************************************
   // Phase generation
   // ****************************************
   logic in_sample, in_sample_reg, samp_start, ab_start;
   logic run_reg;

   assign in_sample = ~(cclk_s2_reg ^ phs_s2_reg);
   assign samp_start = in_sample & ~in_sample_reg;
   assign ab_start = ~in_sample & in_sample_reg;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // Cleared synchronisers decode as sample phase; matching avoids a false start
         in_sample_reg <= 1'b1;
      end else begin
         in_sample_reg <= in_sample;
      end
   end

   // Half-cycle monitor: the source may run below the comparator settling limit
   logic [11:0] half_cnt_reg;
   logic terr_reg, terr_clr;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         half_cnt_reg <= '0;
      end else if (samp_start || ab_start) begin
         half_cnt_reg <= 12'h0001;
      end else if (half_cnt_reg != 12'h000 && half_cnt_reg != 12'hfff) begin
         // Holds at zero until the first phase edge, so that half is never judged
         half_cnt_reg <= half_cnt_reg + 12'h0001;
      end
   end

   // Set wins over a software clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         terr_reg <= 1'b0;
      end else if ((samp_start || ab_start) && half_cnt_reg != '0
                   && half_cnt_reg < 12'(MIN_HALF_CYC)) begin
         terr_reg <= 1'b1;
      end else if (terr_clr) begin
         terr_reg <= 1'b0;
      end
   end

   // ****************************************
   // Latch and two-stage encoder
   // ****************************************
   fadc_stage_s stage_reg;
   fadc_word_s enc_reg;
   fadc_word_s out_reg;

   // Decisions sampled at the end of the sample phase feed the first stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stage_reg <= '0;
      end else if (run_reg && ab_start) begin
         stage_reg.edge_hot <= therm_edge(cmp_s2_reg[THERM_N-1:0]);
         stage_reg.ovr <= cmp_s2_reg[OVR_IDX];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         enc_reg <= '0;
      end else if (run_reg && samp_start) begin
         enc_reg.ovr <= stage_reg.ovr;
         if (stage_reg.ovr) begin
            enc_reg.code <= CODE_FULL;
         end else begin
            enc_reg.code <= edge_code(stage_reg.edge_hot);
         end
      end
   end

   // Loaded one sample later than the encoder: 1.5 converter cycles in all
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         out_reg <= '0;
      end else if (run_reg && samp_start) begin
         out_reg <= enc_reg;
      end
   end

   // ****************************************
   // Pipeline fill and conversion count
   // ****************************************
   logic [1:0] fill_reg;
   logic valid_reg;
   logic [31:0] conv_cnt_reg;

   always_ff @(posedge clk) begin
      if (!rst_n || !run_reg) begin
         fill_reg <= '0;
         valid_reg <= 1'b0;
      end else if (samp_start) begin
         if (fill_reg == FILL_SAMPLES) begin
            valid_reg <= 1'b1;
         end else begin
            fill_reg <= fill_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conv_cnt_reg <= '0;
      end else if (run_reg && samp_start) begin
         conv_cnt_reg <= conv_cnt_reg + 32'h0000_0001;
      end
   end

   // ****************************************
   // Output pins
   // ****************************************
   assign sample_code = out_reg.code;
   assign over_range_flag = out_reg.ovr;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sample_code_oe_n <= 1'b1;
         over_range_flag_oe_n <= 1'b1;
      end else begin
         sample_code_oe_n <= ~(moe_s2_reg & ~den_n_s2_reg);
         over_range_flag_oe_n <= ~moe_s2_reg;
      end
   end

   // ****************************************
   // AHB-Lite register slave
   // ****************************************
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic addr_ok;

   assign addr_ok = hsel && htrans[1] && hready;
   assign terr_clr = wr_pend_reg && wr_addr_reg == STATUS_OFS && hwdata[ST_TERR_BIT];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
      end else begin
         wr_pend_reg <= addr_ok && hwrite;
         wr_addr_reg <= haddr[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run_reg <= CTRL_RUN_RST;
      end else if (wr_pend_reg && wr_addr_reg == CTRL_OFS) begin
         run_reg <= hwdata[CTRL_RUN_BIT];
      end
   end

   // Read data is fetched in the address phase so it leaves a flop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hrdata <= '0;
      end else if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            CTRL_OFS: hrdata <= {31'h0000_0000, run_reg};
            STATUS_OFS: hrdata <= {22'h00_0000, terr_reg, in_sample_reg, valid_reg,
                                   out_reg.ovr, out_reg.code};
            COUNT_OFS: hrdata <= conv_cnt_reg;
            default: hrdata <= '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_phase_edges;
      ab_start |-> !samp_start && $past(in_sample);
   endproperty
   a_phase_edges: assert property (p_phase_edges) else $error("bad phase edge");

   property p_phase_xor;
      (cclk_s2_reg == phs_s2_reg) |=> in_sample_reg;
   endproperty
   a_phase_xor: assert property (p_phase_xor) else $error("phase select wrong");

   property p_stage_latch;
      run_reg && ab_start |=> stage_reg.ovr == $past(cmp_s2_reg[OVR_IDX]);
   endproperty
   a_stage_latch: assert property (p_stage_latch) else $error("latch missed");

   property p_ovr_full;
      out_reg.ovr |-> out_reg.code == CODE_FULL;
   endproperty
   a_ovr_full: assert property (p_ovr_full) else $error("over range code");

   property p_out_moment;
      !$stable(out_reg) |-> $past(samp_start) && $past(run_reg);
   endproperty
   a_out_moment: assert property (p_out_moment) else $error("output moved");

   property p_out_pipe;
      run_reg && samp_start |=> out_reg == $past(enc_reg) && enc_reg.ovr == $past(stage_reg.ovr);
   endproperty
   a_out_pipe: assert property (p_out_pipe) else $error("pipeline slip");

   property p_master_off;
      !moe_s2_reg |=> sample_code_oe_n && over_range_flag_oe_n;
   endproperty
   a_master_off: assert property (p_master_off) else $error("bus not released");

   property p_data_en;
      moe_s2_reg |=> !over_range_flag_oe_n && (sample_code_oe_n == $past(den_n_s2_reg));
   endproperty
   a_data_en: assert property (p_data_en) else $error("data enable wrong");

   property p_fill;
      fill_reg < FILL_SAMPLES |-> !valid_reg;
   endproperty
   a_fill: assert property (p_fill) else $error("valid too early");

   c_over_range: cover property (samp_start && enc_reg.ovr);
   c_valid: cover property (!valid_reg ##1 valid_reg);
   c_data_off: cover property (moe_s2_reg && den_n_s2_reg);
   c_terr: cover property (!terr_reg ##1 terr_reg);

endmodule : fadc_core

/* File: rtl/fadc_pkg.sv */
// Purpose: Shared constants and types for the flash converter control logic
// Assumes: 200 MHz system clock, 32-bit AHB-Lite register access
// Notes: Register offsets are byte addresses of aligned words
package fadc_pkg;

   // ****************************************
   // Sizes
   // ****************************************
   localparam int CODE_W = 6;
   localparam int CMP_N = 64;
   localparam int THERM_N = 63;
   localparam int OVR_IDX = 63;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 5;
   localparam int MIN_HALF_NS = 16;
   localparam int MIN_HALF_CYC = (MIN_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] FILL_SAMPLES = 2'h2;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] COUNT_OFS = 8'h08;
   localparam int CTRL_RUN_BIT = 0;
   localparam int ST_OVR_BIT = 6;
   localparam int ST_VALID_BIT = 7;
   localparam int ST_SAMPLE_BIT = 8;
   localparam int ST_TERR_BIT = 9;
   localparam logic CTRL_RUN_RST = 1'b1;
   localparam logic [CODE_W-1:0] CODE_FULL = 6'h3f;

   typedef struct packed {
      logic ovr;
      logic [CODE_W-1:0] code;
   } fadc_word_s;

   typedef struct packed {
      logic ovr;
      logic [THERM_N-1:0] edge_hot;
   } fadc_stage_s;

endpackage : fadc_pkg

/* File: test/fadc_capture.sv */
// Purpose: Far-side logic that captures words from the three-state output pins
// Assumes: Pins are resolved here from the design's values and active-low enables
// Notes: A released pin shows the inverse of its last driven level, never a held value
module fadc_capture
   import fadc_pkg::*;
(
   input wire logic clk,
   input wire logic [CODE_W-1:0] sample_code,
   input wire logic sample_code_oe_n,
   input wire logic over_range_flag,
   input wire logic over_range_flag_oe_n,
   output logic [CODE_W-1:0] code_bus,
   output logic ovr_bus
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [CODE_W-1:0] last_code = '0;
   logic last_ovr = 1'b0;
   // Undriven pins must not look like fresh data
   assign code_bus = sample_code_oe_n ? ~last_code : sample_code;
   assign ovr_bus = over_range_flag_oe_n ? ~last_ovr : over_range_flag;
   always @(posedge clk) begin
      if (!sample_code_oe_n) last_code <= sample_code;
      if (!over_range_flag_oe_n) last_ovr <= over_range_flag;
   end
endmodule : fadc_capture

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the converter control and output logic
// Assumes: Converter clock made here in half periods of whole system cycles
// Notes: Register access uses zero-wait AHB-Lite single word transfers
module tb_top
   import fadc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, conv_clk = 0, phase_select = 0;
   logic [CMP_N-1:0] cmp_decision = '0;
   logic master_output_enable = 1, data_bus_enable_n = 0;
   logic hsel = 0, hwrite = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [CODE_W-1:0] sample_code, code_bus;
   logic sample_code_oe_n, over_range_flag, over_range_flag_oe_n, ovr_bus, hreadyout, hresp;
   int bad_count = 0, samples_checked = 0;
   fadc_word_s w;

   fadc_core i_dut (.clk(clk), .rst_n(rst_n), .conv_clk(conv_clk), .phase_select(phase_select),
      .cmp_decision(cmp_decision), .master_output_enable(master_output_enable),
      .data_bus_enable_n(data_bus_enable_n), .sample_code(sample_code),
      .sample_code_oe_n(sample_code_oe_n), .over_range_flag(over_range_flag),
      .over_range_flag_oe_n(over_range_flag_oe_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
   fadc_capture i_far (.clk(clk), .sample_code(sample_code), .sample_code_oe_n(sample_code_oe_n),
      .over_range_flag(over_range_flag), .over_range_flag_oe_n(over_range_flag_oe_n),
      .code_bus(code_bus), .ovr_bus(ovr_bus));

   initial begin
      forever #2.5 clk = ~clk;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic end_of_test();
      if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test

   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_reg

   task automatic check_pin(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_pin

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   // Half period of 8 system cycles keeps each half above the 16 ns floor
   task automatic conv_cycles(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge clk);
         conv_clk <= ~conv_clk;
         repeat (half) @(posedge clk);
         conv_clk <= ~conv_clk;
      end
      // The last edge needs two system cycles to cross the pin synchroniser and a third to load the flops
      repeat (4) @(posedge clk);
   endtask : conv_cycles

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      check_pin({6'h00, sample_code_oe_n, over_range_flag_oe_n}, 8'h03);
      ahb(0, CTRL_OFS, 0);
      check_reg(rd, 32'h0000_0001);
      check_pin({7'h00, hresp}, 8'h00);
      ahb(0, 8'h0c, 0);
      check_reg(rd, 32'h0000_0000);
      conv_cycles(2, 8);
      ahb(0, STATUS_OFS, 0);
      check_reg(rd & 32'h0000_0080, 32'h0000_0000);
      conv_cycles(1, 8);
      ahb(0, STATUS_OFS, 0);
      check_reg(rd, 32'h0000_0180);
   endtask : t_reset

   task automatic t_codes();
      int tbl[8] = '{0, 1, 16, 32, 48, 62, 63, 64};
      foreach (tbl[i]) begin
         @(posedge clk);
         cmp_decision <= (tbl[i] == 64) ? '1 : (64'h1 << tbl[i]) - 64'h1;
         w.ovr = (tbl[i] == 64);
         w.code = w.ovr ? CODE_FULL : tbl[i][CODE_W-1:0];
         conv_cycles(3, 8);
         ahb(0, STATUS_OFS, 0);
         check_reg(rd, {24'h00_0001, 1'b1, w});
         check_pin({1'b0, ovr_bus, code_bus}, {1'b0, w});
      end
   endtask : t_codes

   task automatic t_phase();
      @(posedge clk);
      phase_select <= 1;
      cmp_decision <= (64'h1 << 20) - 64'h1;
      conv_cycles(3, 8);
      ahb(0, STATUS_OFS, 0);
      check_reg(rd, 32'h0000_0094);
      @(posedge clk);
      phase_select <= 0;
      conv_cycles(2, 8);
   endtask : t_phase

   task automatic t_count();
      logic [31:0] c0;
      ahb(0, COUNT_OFS, 0);
      c0 = rd;
      conv_cycles(5, 8);
      ahb(0, COUNT_OFS, 0);
      check_reg(rd - c0, 32'h0000_0005);
   endtask : t_count

   task automatic t_run();
      ahb(1, CTRL_OFS, 0);
      ahb(0, STATUS_OFS, 0);
      check_reg(rd & 32'h0000_0080, 32'h0000_0000);
      cmp_decision <= (64'h1 << 10) - 64'h1;
      conv_cycles(3, 8);
      check_pin({2'h0, sample_code}, 8'h14);
      ahb(1, CTRL_OFS, 1);
      conv_cycles(3, 8);
      ahb(0, STATUS_OFS, 0);
      check_reg(rd, 32'h0000_018a);
   endtask : t_run

   task automatic t_terr();
      conv_cycles(2, 2);
      ahb(0, STATUS_OFS, 0);
      check_reg(rd & 32'h0000_0200, 32'h0000_0200);
      conv_cycles(2, 8);
      ahb(1, STATUS_OFS, 32'h0000_0200);
      ahb(0, STATUS_OFS, 0);
      check_reg(rd & 32'h0000_0200, 32'h0000_0000);
   endtask : t_terr

   task automatic t_enable();
      logic [3:0] tbl[4] = '{4'b0011, 4'b0111, 4'b1110, 4'b1000};
      foreach (tbl[i]) begin
         @(posedge clk);
         master_output_enable <= tbl[i][3];
         data_bus_enable_n <= tbl[i][2];
         repeat (5) @(posedge clk);
         check_pin({6'h00, sample_code_oe_n, over_range_flag_oe_n},
                   {6'h00, tbl[i][1:0]});
      end
   endtask : t_enable

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      end_of_test();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1;
      repeat (2) @(posedge clk);
      t_reset();
      t_codes();
      t_phase();
      t_count();
      t_run();
      t_terr();
      t_enable();
      end_of_test();
   end
endmodule : tb_top
